// File: src/sysref_capture_regs.svh
// Register offsets, field positions and reset values of the SYSREF capture controls
`ifndef SYSREF_CAPTURE_REGS_SVH
`define SYSREF_CAPTURE_REGS_SVH

// ----------------------------------------------------------------
// Register offsets on the parallel register port
// ----------------------------------------------------------------
`define SYSREF_CAPTURE_CTRL_OFS    8'h29
`define CLOCK_INPUT_MODE_CTRL_OFS  8'h2a
`define CAPTURE_POS_BYTE0_OFS      8'h2c
`define CAPTURE_POS_BYTE1_OFS      8'h2d
`define CAPTURE_POS_BYTE2_OFS      8'h2e

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SYSREF_CAPTURE_CTRL_RESET  8'h80
`define CLOCK_INPUT_MODE_RESET     8'h00
`define UNMAPPED_READ_VALUE        8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_RESERVED_ONE_BIT      7
`define CTRL_PROC_EN_BIT           6
`define CTRL_RECV_EN_BIT           5
`define CTRL_FINE_SCALE_BIT        4
`define CTRL_DELAY_SEL_MSB         3
`define CTRL_DELAY_SEL_LSB         0
`define MODE_INVERT_BIT            0
`define MODE_REF_PECL_BIT          1
`define MODE_DEVICE_SAMPLE_CLOCK_PECL_BIT       2

// ----------------------------------------------------------------
// Capture path sizes
// ----------------------------------------------------------------
`define CAPTURE_HISTORY_DEPTH      48
`define CAPTURE_POSITION_WIDTH     24

`endif

// File: src/sysref_capture_pkg.sv
// Types shared by the SYSREF capture control block
`default_nettype none

package sysref_capture_pkg;

    // Layout of the SYSREF capture control register
    typedef struct packed {
        logic       reserved_one;
        logic       ref_event_processor_enable;
        logic       ref_receiver_enable;
        logic       fine_window_scale;
        logic [3:0] capture_delay_select;
    } sysref_capture_ctrl_s;

    // Layout of the clock input mode register
    typedef struct packed {
        logic [4:0] reserved;
        logic       device_sample_clock_pecl_input_mode;
        logic       ref_pecl_input_mode;
        logic       ref_polarity_invert;
    } clock_input_mode_ctrl_s;

endpackage

`default_nettype wire

// File: src/sysref_capture_path.sv
// SYSREF conditioning, selectable sampling delay and edge position capture
`timescale 1ns/100ps
`default_nettype none
`include "sysref_capture_regs.svh"

module sysref_capture_path
    import sysref_capture_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        sysref_i,
    input  wire logic        recv_en_i,
    input  wire logic        proc_en_i,
    input  wire logic        fine_i,
    input  wire logic        invert_i,
    input  wire logic [3:0]  delay_sel_i,
    output logic             event_o,
    output logic [23:0]      position_o
);

    logic [`CAPTURE_HISTORY_DEPTH-1:0]  hist;
    logic [`CAPTURE_HISTORY_DEPTH-1:0]  next_hist;
    logic                               prev_tap;
    logic                               next_prev_tap;
    logic                               next_event;
    logic [23:0]                        next_position;
    logic [23:0]                        view;
    logic [4:0]                         tap;
    logic                               rx;

    // ----------------------------------------------------------------
    // Position view: fine scale looks at every sample, coarse at every other
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CAPTURE_POSITION_WIDTH; gi = gi + 1) begin : g_view
            assign view[gi] = fine_i ? hist[gi] : hist[2*gi];
        end
    endgenerate

    // Coarse steps are twice as long, so the same code reaches twice as far
    assign tap = fine_i ? {1'b0, delay_sel_i} : {delay_sel_i, 1'b0};

    // Receiver off means the line is held quiet; polarity is applied at the input
    assign rx = recv_en_i & (sysref_i ^ invert_i);

    // Next values of the capture path
    always_comb begin
        next_hist     = {hist[`CAPTURE_HISTORY_DEPTH-2:0], rx};
        next_prev_tap = hist[tap];
        // Gate on both enables so a mis-ordered host setup cannot fire events
        next_event    = proc_en_i & recv_en_i & hist[tap] & ~prev_tap;
        next_position = next_event ? view : position_o;
    end

    // Capture path registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hist       <= '0;
            prev_tap   <= 1'b0;
            event_o    <= 1'b0;
            position_o <= '0;
        end else begin
            hist       <= next_hist;
            prev_tap   <= next_prev_tap;
            event_o    <= next_event;
            position_o <= next_position;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // A fresh rise one sample deep fires at once on the fine scale with select zero
    a_fine_tap_step: assert property (
        fine_i && $stable(fine_i) && delay_sel_i == 4'h0 && $stable(delay_sel_i) &&
            proc_en_i && recv_en_i && hist[0] && !hist[1] |=> event_o)
        else $error("fine scale event not at its sample");
    // On the coarse scale select four must wait for the rise to reach sample eight
    a_coarse_tap_step: assert property (
        !fine_i && $stable(fine_i) && delay_sel_i == 4'h4 && $stable(delay_sel_i) &&
            proc_en_i && recv_en_i && hist[8] && !hist[9] |=> event_o)
        else $error("coarse scale event not at twice the select");
    a_invert_input: assert property (recv_en_i && invert_i |=> hist[0] == !$past(sysref_i))
        else $error("inverted sysref not sampled");
    a_position_latch: assert property (event_o |-> position_o == $past(view))
        else $error("position not captured with event");

endmodule // sysref_capture_path

`default_nettype wire

// File: src/sysref_capture_control.sv
// SYSREF capture control registers and their static control outputs
`timescale 1ns/100ps
`default_nettype none
`include "sysref_capture_regs.svh"

module sysref_capture_control
    import sysref_capture_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        reg_wr_en_i,
    input  wire logic        reg_rd_en_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        sysref_i,
    output logic [7:0]       reg_rdata_o,
    output logic             ref_event_processor_enable_o,
    output logic             ref_receiver_enable_o,
    output logic             fine_window_scale_o,
    output logic [3:0]       capture_delay_select_o,
    output logic             ref_polarity_invert_o,
    output logic             ref_pecl_input_mode_o,
    output logic             device_sample_clock_pecl_input_mode_o,
    output logic             sysref_event_o,
    output logic [23:0]      capture_position_status_o
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    sysref_capture_ctrl_s    sysref_capture_ctrl;
    sysref_capture_ctrl_s    next_sysref_capture_ctrl;
    clock_input_mode_ctrl_s  clock_input_mode_ctrl;
    clock_input_mode_ctrl_s  next_clock_input_mode_ctrl;
    logic [7:0]              rdata;
    logic [7:0]              next_rdata;
    logic [23:0]             position;

    // Write decode: bit 7 is stored as written, keeping it one is the host's duty
    always_comb begin
        next_sysref_capture_ctrl   = sysref_capture_ctrl;
        next_clock_input_mode_ctrl = clock_input_mode_ctrl;
        if (reg_wr_en_i) begin
            if (reg_addr_i == `SYSREF_CAPTURE_CTRL_OFS) begin
                next_sysref_capture_ctrl = sysref_capture_ctrl_s'(reg_wdata_i);
            end
            if (reg_addr_i == `CLOCK_INPUT_MODE_CTRL_OFS) begin
                next_clock_input_mode_ctrl = clock_input_mode_ctrl_s'(reg_wdata_i);
            end
        end
    end

    // Configuration registers; reset leaves every SYSREF function disabled
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sysref_capture_ctrl   <= sysref_capture_ctrl_s'(`SYSREF_CAPTURE_CTRL_RESET);
            clock_input_mode_ctrl <= clock_input_mode_ctrl_s'(`CLOCK_INPUT_MODE_RESET);
        end else begin
            sysref_capture_ctrl   <= next_sysref_capture_ctrl;
            clock_input_mode_ctrl <= next_clock_input_mode_ctrl;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Read data is registered and held until the next read
    always_comb begin
        next_rdata = rdata;
        if (reg_rd_en_i) begin
            case (reg_addr_i)
                `SYSREF_CAPTURE_CTRL_OFS:   next_rdata = sysref_capture_ctrl;
                `CLOCK_INPUT_MODE_CTRL_OFS: next_rdata = clock_input_mode_ctrl;
                `CAPTURE_POS_BYTE0_OFS:     next_rdata = position[7:0];
                `CAPTURE_POS_BYTE1_OFS:     next_rdata = position[15:8];
                `CAPTURE_POS_BYTE2_OFS:     next_rdata = position[23:16];
                default:                    next_rdata = `UNMAPPED_READ_VALUE;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata <= `UNMAPPED_READ_VALUE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Capture path
    // ----------------------------------------------------------------

    // Controls reach the path straight from the registers, no extra stage
    sysref_capture_path u_path (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .sysref_i    (sysref_i),
        .recv_en_i   (sysref_capture_ctrl.ref_receiver_enable),
        .proc_en_i   (sysref_capture_ctrl.ref_event_processor_enable),
        .fine_i      (sysref_capture_ctrl.fine_window_scale),
        .invert_i    (clock_input_mode_ctrl.ref_polarity_invert),
        .delay_sel_i (sysref_capture_ctrl.capture_delay_select),
        .event_o     (sysref_event_o),
        .position_o  (position)
    );

    // ----------------------------------------------------------------
    // Outputs: read data, each non-reserved control register field, and the position status
    // ----------------------------------------------------------------
    assign reg_rdata_o                  = rdata;
    assign ref_event_processor_enable_o = sysref_capture_ctrl.ref_event_processor_enable;
    assign ref_receiver_enable_o        = sysref_capture_ctrl.ref_receiver_enable;
    assign fine_window_scale_o          = sysref_capture_ctrl.fine_window_scale;
    assign capture_delay_select_o       = sysref_capture_ctrl.capture_delay_select;
    assign ref_polarity_invert_o        = clock_input_mode_ctrl.ref_polarity_invert;
    // Termination controls: a set bit means 50 ohm to ground, no self-bias
    assign ref_pecl_input_mode_o        = clock_input_mode_ctrl.ref_pecl_input_mode;
    assign device_sample_clock_pecl_input_mode_o     = clock_input_mode_ctrl.device_sample_clock_pecl_input_mode;
    assign capture_position_status_o    = position;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking

    // No disable here, so the check can look inside the reset itself
    a_reset_values: assert property (
        rst_i && $past(rst_i) |-> reg_rdata_o == `UNMAPPED_READ_VALUE &&
            !ref_receiver_enable_o && !sysref_event_o &&
            sysref_capture_ctrl == `SYSREF_CAPTURE_CTRL_RESET &&
            clock_input_mode_ctrl == `CLOCK_INPUT_MODE_RESET)
        else $error("registers not at reset values");

    a_ctrl_write_edge: assert property (disable iff (rst_i)
        reg_wr_en_i && reg_addr_i == `SYSREF_CAPTURE_CTRL_OFS |=>
            {ref_event_processor_enable_o, ref_receiver_enable_o, fine_window_scale_o,
             capture_delay_select_o} == $past(reg_wdata_i[6:0]))
        else $error("capture control outputs missed a write");

    // Configuration only moves on a write to its own offset
    a_ctrl_hold: assert property (disable iff (rst_i)
        !(reg_wr_en_i && reg_addr_i == `SYSREF_CAPTURE_CTRL_OFS) |=>
            $stable(sysref_capture_ctrl))
        else $error("capture control changed without a write");

    a_mode_hold: assert property (disable iff (rst_i)
        !(reg_wr_en_i && reg_addr_i == `CLOCK_INPUT_MODE_CTRL_OFS) |=>
            $stable(clock_input_mode_ctrl))
        else $error("input mode changed without a write");

    a_proc_off_quiet: assert property (disable iff (rst_i)
        !ref_event_processor_enable_o |=> !sysref_event_o)
        else $error("event while processor disabled");

    a_recv_off_quiet: assert property (disable iff (rst_i)
        !ref_receiver_enable_o [*2] |=> !sysref_event_o)
        else $error("event while receiver disabled");

    // A processed edge leaves its own tap high, so it cannot fire twice in a row
    a_event_pulse: assert property (disable iff (rst_i)
        sysref_event_o |=> !sysref_event_o)
        else $error("event longer than one cycle");

    a_pecl_mode_write: assert property (disable iff (rst_i)
        reg_wr_en_i && reg_addr_i == `CLOCK_INPUT_MODE_CTRL_OFS |=>
            ref_pecl_input_mode_o == $past(reg_wdata_i[1]) &&
            device_sample_clock_pecl_input_mode_o == $past(reg_wdata_i[2]))
        else $error("input mode outputs missed a write");

    a_invert_write: assert property (disable iff (rst_i)
        reg_wr_en_i && reg_addr_i == `CLOCK_INPUT_MODE_CTRL_OFS |=>
            ref_polarity_invert_o == $past(reg_wdata_i[0]))
        else $error("polarity invert missed a write");

    // A read in the same cycle as a write still returns the old value
    a_ctrl_readback: assert property (disable iff (rst_i)
        reg_rd_en_i && reg_addr_i == `SYSREF_CAPTURE_CTRL_OFS |=>
            reg_rdata_o == $past(sysref_capture_ctrl))
        else $error("capture control read back wrong");

    a_rdata_hold: assert property (disable iff (rst_i)
        !reg_rd_en_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");

    // Position bytes are not snapshotted together; each read sees the live status
    a_position_low: assert property (disable iff (rst_i)
        reg_rd_en_i && reg_addr_i == `CAPTURE_POS_BYTE0_OFS |=>
            reg_rdata_o == $past(position[7:0]))
        else $error("position low byte read wrong");

    a_position_read: assert property (disable iff (rst_i)
        reg_rd_en_i && reg_addr_i == `CAPTURE_POS_BYTE1_OFS |=>
            reg_rdata_o == $past(position[15:8]))
        else $error("position byte read wrong");

    a_position_high: assert property (disable iff (rst_i)
        reg_rd_en_i && reg_addr_i == `CAPTURE_POS_BYTE2_OFS |=>
            reg_rdata_o == $past(position[23:16]))
        else $error("position high byte read wrong");

    // Status is read-only: only a processed event may move it
    a_position_event: assert property (disable iff (rst_i)
        !$stable(capture_position_status_o) |-> sysref_event_o)
        else $error("position moved without an event");

    a_unmapped_read: assert property (disable iff (rst_i)
        reg_rd_en_i && !(reg_addr_i inside {`SYSREF_CAPTURE_CTRL_OFS,
            `CLOCK_INPUT_MODE_CTRL_OFS, `CAPTURE_POS_BYTE0_OFS, `CAPTURE_POS_BYTE1_OFS,
            `CAPTURE_POS_BYTE2_OFS}) |=> reg_rdata_o == `UNMAPPED_READ_VALUE)
        else $error("unmapped read not zero");

    // Main scenarios: setup write, events on both scales, status read
    c_ctrl_write:   cover property (disable iff (rst_i)
        reg_wr_en_i && reg_addr_i == `SYSREF_CAPTURE_CTRL_OFS);
    c_event_seen:   cover property (disable iff (rst_i) sysref_event_o);
    c_fine_event:   cover property (disable iff (rst_i) sysref_event_o && fine_window_scale_o);
    c_coarse_event: cover property (disable iff (rst_i) sysref_event_o && !fine_window_scale_o);
    c_pos_read:     cover property (disable iff (rst_i)
        reg_rd_en_i && reg_addr_i == `CAPTURE_POS_BYTE2_OFS);

endmodule // sysref_capture_control

`default_nettype wire

// File: testbench/host_reg_master.sv
// Host model that programs the SYSREF capture registers over the register port
`timescale 1ns/100ps
`default_nettype none
`include "sysref_capture_regs.svh"

module host_reg_master
    import sysref_capture_pkg::*;
(
    input  wire logic       sys_clk_i,
    output logic            reg_wr_en_o,
    output logic            reg_rd_en_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    logic recv_on;

    // Idle bus at time zero
    initial begin
        reg_wr_en_o = 1'b0;
        reg_rd_en_o = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        recv_on     = 1'b0;
    end

    // One strobe cycle, then a quiet cycle so a strobe is never re-driven in one step;
    // released address and data are inverted so stale values never look valid
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        reg_wr_en_o = wr;
        reg_rd_en_o = !wr;
        reg_addr_o  = addr;
        reg_wdata_o = data;
        @(posedge sys_clk_i);
        #5;
        reg_wr_en_o = 1'b0;
        reg_rd_en_o = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
        @(posedge sys_clk_i);
        #5;
    endtask

    // Read one byte; the registered answer holds until the next read
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        access(1'b0, addr, 8'h00);
        data = reg_rdata_i;
    endtask

    // Capture control write that keeps the host's side of the enable order
    task automatic write_ctrl(input logic proc, input logic recv, input logic fine,
                              input logic [3:0] sel);
        sysref_capture_ctrl_s c;
        c = '{reserved_one: 1'b1, ref_event_processor_enable: 1'b0,
              ref_receiver_enable: recv | proc, fine_window_scale: fine,
              capture_delay_select: sel};
        if (proc && !recv_on) begin
            access(1'b1, `SYSREF_CAPTURE_CTRL_OFS, c);
        end
        c.ref_event_processor_enable = proc;
        access(1'b1, `SYSREF_CAPTURE_CTRL_OFS, c);
        recv_on = c.ref_receiver_enable;
    endtask

    // Mode write; reserved bits go back at their default of zero
    task automatic write_mode(input logic [2:0] mode);
        access(1'b1, `CLOCK_INPUT_MODE_CTRL_OFS, {5'h00, mode});
    endtask
endmodule // host_reg_master
`default_nettype wire

// File: testbench/sysref_capture_control_test.sv
// Self-checking testbench of the SYSREF capture control block
`timescale 1ns/100ps
`default_nettype none
`include "sysref_capture_regs.svh"

module sysref_capture_control_test
    import sysref_capture_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        sysref = 1'b0;
    logic        wr_en, rd_en, proc_en, recv_en, fine, inv, ref_pecl, dev_pecl, evt;
    logic [7:0]  addr, wdata, rdata, rd;
    logic [3:0]  sel;
    logic [23:0] position;
    int          err_total = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          d0, d1, d2, d3;

    // ----------------------------------------------------------------
    // Clock, design and host
    // ----------------------------------------------------------------
    initial forever #25 sys_clk = ~sys_clk;

    sysref_capture_control dut (.sys_clk_i(sys_clk), .rst_i(rst), .reg_wr_en_i(wr_en),
        .reg_rd_en_i(rd_en), .reg_addr_i(addr), .reg_wdata_i(wdata), .sysref_i(sysref),
        .reg_rdata_o(rdata), .ref_event_processor_enable_o(proc_en),
        .ref_receiver_enable_o(recv_en), .fine_window_scale_o(fine),
        .capture_delay_select_o(sel), .ref_polarity_invert_o(inv),
        .ref_pecl_input_mode_o(ref_pecl), .device_sample_clock_pecl_input_mode_o(dev_pecl),
        .sysref_event_o(evt), .capture_position_status_o(position));

    host_reg_master host (.sys_clk_i(sys_clk), .reg_wr_en_o(wr_en), .reg_rd_en_o(rd_en),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Quiet SYSREF long enough to flush the history, then step it; edges until the
    // event, or zero when none comes within the window
    task automatic lat(input logic lvl, output int d);
        d = 0;
        sysref = ~lvl;
        repeat (50) @(posedge sys_clk);
        #5 sysref = lvl;
        for (int i = 1; i <= 80 && d == 0; i++) begin
            @(posedge sys_clk);
            #5;
            if (evt === 1'b1) d = i;
        end
    endtask

    // A hang ends the run as a failure
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        #5 rst = 1'b0;
        host.read_reg(`SYSREF_CAPTURE_CTRL_OFS, rd);
        check("ctrl reset", rd, 24'h80);
        host.read_reg(`CLOCK_INPUT_MODE_CTRL_OFS, rd);
        check("mode reset", rd, 24'h00);
        check("outputs reset", {proc_en, recv_en, fine, sel, inv, ref_pecl, dev_pecl}, 0);
        // Every mode combination reaches its control output and reads back
        for (int m = 7; m >= 0; m--) begin
            host.write_mode(m[2:0]);
            check("mode outputs", {dev_pecl, ref_pecl, inv}, m);
            host.read_reg(`CLOCK_INPUT_MODE_CTRL_OFS, rd);
            check("mode readback", rd, m);
        end
        // Receiver alone: control visible, events still ignored
        host.write_ctrl(1'b0, 1'b1, 1'b0, 4'ha);
        check("recv only", {proc_en, recv_en, sel}, 6'h1a);
        lat(1'b1, d0);
        check("no event", d0, 0);
        // Delay select and scale move the event by exact sample counts
        host.write_ctrl(1'b1, 1'b1, 1'b1, 4'h0);
        lat(1'b1, d0);
        check("event seen", d0 > 0, 1);
        host.write_ctrl(1'b1, 1'b1, 1'b1, 4'h4);
        check("fine controls", {proc_en, recv_en, fine, sel}, 7'h74);
        lat(1'b1, d1);
        check("fine delay", d1 - d0, 4);
        host.write_ctrl(1'b1, 1'b1, 1'b0, 4'h4);
        lat(1'b1, d2);
        check("coarse delay", d2 - d0, 8);
        check("position", position, 24'h00001f);
        host.read_reg(`CAPTURE_POS_BYTE2_OFS, rd);
        check("position top", rd, 0);
        host.read_reg(`CAPTURE_POS_BYTE0_OFS, rd);
        check("position low", rd, 8'h1f);
        host.access(1'b1, `CAPTURE_POS_BYTE2_OFS, 8'hff);
        host.read_reg(`CAPTURE_POS_BYTE2_OFS, rd);
        check("position ro", rd, 0);
        // Inverted SYSREF: a falling input edge is the event
        host.write_mode(3'h1);
        lat(1'b0, d3);
        check("invert", d3, d2);
        // Unmapped place ignores writes and reads zero; controls untouched
        host.access(1'b1, 8'h2b, 8'h5a);
        host.read_reg(8'h2b, rd);
        check("unmapped", rd, 0);
        host.read_reg(`SYSREF_CAPTURE_CTRL_OFS, rd);
        check("ctrl kept", rd, 24'he4);
        // Reset in mid-run brings every control and the status back to reset values
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #5 rst = 1'b0;
        check("reset", {proc_en, recv_en, fine, sel, inv, ref_pecl, dev_pecl, evt}, 0);
        check("reset rdata", rdata, 0);
        check("reset position", position, 0);
        host.read_reg(`SYSREF_CAPTURE_CTRL_OFS, rd);
        check("ctrl after reset", rd, 24'h80);
        print_verdict();
    end
endmodule // sysref_capture_control_test
`default_nettype wire
